/* design/ptp_timer.sv */
// Pulse timer pair: byte and word counter/timers with APB register slave
`timescale 1ns/100ps
`default_nettype none
`include "ptp_defines.svh"

module ptp_timer (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // Pin inputs
    input  wire logic        port3Bit1Input,
    input  wire logic        port2Bit0Input,
    input  wire logic        comparatorResult,
    // Pin outputs
    output var  logic        firstFixedOutputPin,
    output var  logic        secondFixedOutputPin,
    output var  logic        thirdFixedOutputPin,
    output var  logic        comparatorEnable,
    // Interrupt requests
    output var  logic        byteTimerIrq,
    output var  logic        wordTimerIrq
);
    import ptp_pkg::*;

    // One struct of state, filled by the comb process
    // and copied back by the clocked one
    ptp_state_t  st_ff;
    ptp_state_t  nxt_st;

    //--------------------------------------------------------------------------
    // Next-state logic
    //--------------------------------------------------------------------------

    // Working values of one cycle
    // Bus decode and write data
    logic        wrDone;
    logic        rdTake;
    logic [5:0]  idx;
    logic        addrOk;
    logic [7:0]  wb;
    // Input path and edges
    logic        rawIn;
    logic        posEdge;
    logic        negEdge;
    logic        selEdge;
    // Prescaler ticks
    logic        bTick;
    logic        wTick;
    // Third pin source
    logic        combOut;
    // Filter width and read data
    logic [2:0]  fltLen;
    logic [31:0] rd;

    always_comb begin
        nxt_st  = st_ff;
        idx     = paddr[7:2];
        addrOk  = (paddr[1:0] == 2'h0) && (idx <= `PTP_IDX_WCAP);
        wb      = pwdata[7:0];
        wrDone  = psel && penable && st_ff.pready && pwrite;
        rdTake  = psel && penable && !st_ff.pready;

        // Prescaler shared by both timers
        // Free-running, so both timers tick in step
        // Code 3 shifts the one out: mask 7, every eighth
        nxt_st.pre = st_ff.pre + 3'h1;
        bTick = (st_ff.pre & ((3'h1 << st_ff.bPre) - 3'h1)) == 3'h0;
        wTick = (st_ff.pre & ((3'h1 << st_ff.wPre) - 3'h1)) == 3'h0;

        // Measured input: comparator replaces the pin when enabled
        // Route bit set takes the second measured pin
        if (st_ff.route) begin
            rawIn = port2Bit0Input;
        end else begin
            rawIn = st_ff.cmpEn ? comparatorResult : port3Bit1Input;
        end

        // Glitch filter: input must differ for 1, 2, 4 or 8 cycles
        // Short pulses never reach the edge detector
        // Count restarts whenever the input agrees
        fltLen = (3'h1 << st_ff.glitch) - 3'h1;
        if (rawIn == st_ff.flt) begin
            nxt_st.fltCnt = 3'h0;
        end else if (st_ff.fltCnt >= fltLen) begin
            nxt_st.flt    = rawIn;
            nxt_st.fltCnt = 3'h0;
        end else begin
            nxt_st.fltCnt = st_ff.fltCnt + 3'h1;
        end
        nxt_st.fltPrev = st_ff.flt;

        // Edge detector on the filtered level
        // Both lines idle low after reset
        // Edges show in the first cycle of the new filtered level
        // Code 11 selects no edge
        posEdge = st_ff.flt && !st_ff.fltPrev;
        negEdge = !st_ff.flt && st_ff.fltPrev;
        unique case (st_ff.logicSel)
            2'h0:    selEdge = negEdge;
            2'h1:    selEdge = posEdge;
            2'h2:    selEdge = posEdge || negEdge;
            default: selEdge = 1'b0;
        endcase

        // Register writes; flag clears happen before hardware sets
        // A same-cycle hardware set wins
        if (wrDone && addrOk) begin
            unique case (idx)
                `PTP_IDX_BCTL: begin
                    nxt_st.bEn      = wb[`PTP_B_EN];
                    nxt_st.bSingle  = wb[`PTP_B_SINGLE];
                    if (wb[`PTP_B_TO]) nxt_st.bTo = 1'b0;
                    nxt_st.bPre     = wb[4:3];
                    nxt_st.bCapMask = wb[`PTP_B_CAPMSK];
                    nxt_st.bToMask  = wb[`PTP_B_TOMSK];
                    nxt_st.bOutSel  = wb[`PTP_B_OUTSEL];
                end
                `PTP_IDX_SHCTL: begin
                    nxt_st.mode     = wb[`PTP_B_MODE];
                    nxt_st.route    = wb[`PTP_B_ROUTE];
                    nxt_st.logicSel = wb[5:4];
                    nxt_st.glitch   = wb[3:2];
                    // Transmit: status is plain storage
                    if (st_ff.mode) begin
                        nxt_st.status = st_ff.status & ~wb[1:0];
                    end else begin
                        nxt_st.status = wb[1:0];
                    end
                end
                `PTP_IDX_WCTL: begin
                    nxt_st.wEn      = wb[`PTP_B_EN];
                    nxt_st.wSingle  = wb[`PTP_B_SINGLE];
                    if (wb[`PTP_B_TO]) nxt_st.wTo = 1'b0;
                    nxt_st.wPre     = wb[4:3];
                    nxt_st.wCapMask = wb[`PTP_B_CAPMSK];
                    nxt_st.wToMask  = wb[`PTP_B_TOMSK];
                    nxt_st.wOutSel  = wb[`PTP_B_OUTSEL];
                end
                `PTP_IDX_RUN: begin
                    // Aliases of both enables
                    nxt_st.wEn  = wb[`PTP_B_RUNW];
                    nxt_st.bEn  = wb[`PTP_B_RUNB];
                    nxt_st.sync = wb[`PTP_B_SYNC];
                end
                // Plain storage registers
                `PTP_IDX_RELLO:  nxt_st.relLo   = wb;
                `PTP_IDX_RELHI:  nxt_st.relHi   = wb;
                `PTP_IDX_P3MODE: nxt_st.p3Mode  = wb;
                `PTP_IDX_PORT:   nxt_st.portOut = wb;
                `PTP_IDX_WREL:   nxt_st.wReload = pwdata[15:0];
                default: begin
                end
            endcase
        end

        // Byte timer
        // Idle level is the inverse of shared bit 1
        if (!st_ff.bEn) begin
            nxt_st.bRun = 1'b0;
            nxt_st.bOut = !st_ff.status[1];
        end else if (!st_ff.mode) begin
            // Transmit: high phase counts high reload, low phase low reload
            // Loads on the first enabled cycle
            // Single pass drops the enable
            if (!st_ff.bRun) begin
                nxt_st.bRun = 1'b1;
                nxt_st.bCnt = st_ff.bOut ? st_ff.relHi : st_ff.relLo;
            end else if (bTick) begin
                if (st_ff.bCnt == 8'h00) begin
                    nxt_st.bTo  = 1'b1;
                    nxt_st.bOut = !st_ff.bOut;
                    nxt_st.bCnt = st_ff.bOut ? st_ff.relLo : st_ff.relHi;
                    if (st_ff.bSingle) begin
                        nxt_st.bEn  = 1'b0;
                        nxt_st.bRun = 1'b0;
                    end
                end else begin
                    nxt_st.bCnt = st_ff.bCnt - 8'h01;
                end
            end
        end else begin
            // Demodulation: wait for the first edge, then measure
            // Reload registers unused: restarts at FFh
            if (!st_ff.bRun) begin
                if (selEdge) begin
                    nxt_st.bRun = 1'b1;
                    nxt_st.bCnt = `PTP_BYTE_FULL;
                end
            end else if (selEdge) begin
                // Rising to low, falling to high capture
                if (posEdge) begin
                    nxt_st.capLo     = ~st_ff.bCnt;
                    nxt_st.status[1] = 1'b1;
                end else begin
                    nxt_st.capHi     = ~st_ff.bCnt;
                    nxt_st.status[0] = 1'b1;
                end
                nxt_st.bCnt = `PTP_BYTE_FULL;
            end else if (bTick) begin
                // Timeout on 1 to 0 only
                if (st_ff.bCnt == 8'h01) begin
                    nxt_st.bTo = 1'b1;
                end
                nxt_st.bCnt = st_ff.bCnt - 8'h01; // 0 to FFh sets no flag
            end
        end

        // Word timer
        // Same scheme, one 16-bit reload
        if (!st_ff.wEn) begin
            nxt_st.wRun = 1'b0;
        end else if (!st_ff.mode) begin
            // Output toggles at each terminal count
            if (!st_ff.wRun) begin
                nxt_st.wRun = 1'b1;
                nxt_st.wCnt = st_ff.wReload;
            end else if (wTick) begin
                if (st_ff.wCnt == 16'h0000) begin
                    nxt_st.wTo  = 1'b1;
                    nxt_st.wOut = !st_ff.wOut;
                    nxt_st.wCnt = st_ff.wReload;
                    if (st_ff.wSingle) begin
                        nxt_st.wEn  = 1'b0;
                        nxt_st.wRun = 1'b0;
                    end
                end else begin
                    nxt_st.wCnt = st_ff.wCnt - 16'h0001;
                end
            end
        end else begin
            // With single pass clear, first edge starts, later ones capture
            if (selEdge && !st_ff.wSingle) begin
                nxt_st.wRun = 1'b1;
                // Capture holds the complemented count
                if (st_ff.wRun) begin
                    nxt_st.wCap = ~st_ff.wCnt;
                end
                nxt_st.wCnt = `PTP_WORD_FULL;
            end else if (st_ff.wRun && wTick) begin
                if (st_ff.wCnt == 16'h0001) begin
                    nxt_st.wTo = 1'b1;
                end
                nxt_st.wCnt = st_ff.wCnt - 16'h0001;
            end
        end

        // Output combiner for the third pin
        // Evaluated always, used in transmit with route set
        unique case (ptp_logic_t'(st_ff.logicSel))
            PTP_LOG_AND:  combOut = st_ff.bOut & st_ff.wOut;
            PTP_LOG_OR:   combOut = st_ff.bOut | st_ff.wOut;
            PTP_LOG_NOR:  combOut = ~(st_ff.bOut | st_ff.wOut);
            PTP_LOG_NAND: combOut = ~(st_ff.bOut & st_ff.wOut);
        endcase

        // Pin routing
        // One cycle behind their controls
        // Third pin combines only in transmit
        nxt_st.pin1  = st_ff.bOutSel ? st_ff.bOut : st_ff.portOut[`PTP_B_PIN1];
        nxt_st.pin2  = st_ff.wOutSel ? st_ff.wOut : st_ff.portOut[`PTP_B_PIN2];
        nxt_st.pin3  = (!st_ff.mode && st_ff.route) ? combOut
                                                    : st_ff.portOut[`PTP_B_PIN3];
        nxt_st.cmpEn = st_ff.p3Mode[`PTP_B_CMPEN];

        // Interrupt requests: flags gated by masks
        // Levels, falling a cycle after a clear
        // Capture terms need demodulation mode
        nxt_st.irqByte = (st_ff.bTo && st_ff.bToMask)
                      || (st_ff.mode && (st_ff.status != 2'h0) && st_ff.bCapMask);
        nxt_st.irqWord = (st_ff.wTo && st_ff.wToMask)
                      || (st_ff.mode && st_ff.wRun && st_ff.wCapMask && !st_ff.wSingle
                          && (st_ff.wCap != `PTP_RST_WORD));

        // Read mux
        // Unused bits read zero
        // Run control pads with ones
        unique case (idx)
            `PTP_IDX_BCTL:   rd = {24'h0, st_ff.bEn, st_ff.bSingle, st_ff.bTo, st_ff.bPre,
                                   st_ff.bCapMask, st_ff.bToMask, st_ff.bOutSel};
            `PTP_IDX_SHCTL:  rd = {24'h0, st_ff.mode, st_ff.route, st_ff.logicSel,
                                   st_ff.glitch, st_ff.status};
            `PTP_IDX_WCTL:   rd = {24'h0, st_ff.wEn, st_ff.wSingle, st_ff.wTo, st_ff.wPre,
                                   st_ff.wCapMask, st_ff.wToMask, st_ff.wOutSel};
            `PTP_IDX_RUN:    rd = {24'h0, st_ff.wEn, st_ff.bEn, st_ff.sync,
                                   `PTP_RUN_RSVD};
            `PTP_IDX_RELLO:  rd = {24'h0, st_ff.relLo};
            `PTP_IDX_RELHI:  rd = {24'h0, st_ff.relHi};
            `PTP_IDX_CAPLO:  rd = {24'h0, st_ff.capLo};
            `PTP_IDX_CAPHI:  rd = {24'h0, st_ff.capHi};
            `PTP_IDX_P3MODE: rd = {24'h0, st_ff.p3Mode};
            `PTP_IDX_PORT:   rd = {24'h0, st_ff.portOut};
            `PTP_IDX_WREL:   rd = {16'h0, st_ff.wReload};
            `PTP_IDX_WCAP:   rd = {16'h0, st_ff.wCap};
            default:         rd = 32'h0;
        endcase

        // APB answer one cycle into the access phase
        // One wait state on every transfer
        // Read data held until the next transfer
        nxt_st.pready  = rdTake;
        nxt_st.pslverr = rdTake && !addrOk;
        if (rdTake) begin
            nxt_st.prdata = (addrOk && !pwrite) ? rd : 32'h0;
        end
    end

    //--------------------------------------------------------------------------
    // State register
    //--------------------------------------------------------------------------

    // Synchronous reset; byte output idles high
    // to match the level before enable
    always_ff @(posedge clk) begin
        if (reset) begin
            st_ff         <= '0;
            st_ff.bOut    <= 1'b1;
            st_ff.relLo   <= `PTP_RST_BYTE;
            st_ff.relHi   <= `PTP_RST_BYTE;
            st_ff.wReload <= `PTP_RST_WORD;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from flip-flops
    // No logic between register and pin
    assign prdata               = st_ff.prdata;
    assign pready               = st_ff.pready;
    assign pslverr              = st_ff.pslverr;
    assign firstFixedOutputPin  = st_ff.pin1;
    assign secondFixedOutputPin = st_ff.pin2;
    assign thirdFixedOutputPin  = st_ff.pin3;
    assign comparatorEnable     = st_ff.cmpEn;
    assign byteTimerIrq         = st_ff.irqByte;
    assign wordTimerIrq         = st_ff.irqWord;

endmodule // ptp_timer
`default_nettype wire

/* include/ptp_defines.svh */
// Register indices, field positions, reset values and constants of the pulse timer pair
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
`ifndef PTP_DEFINES_SVH
`define PTP_DEFINES_SVH

// Register indices; byte address is four times the index
`define PTP_IDX_BCTL   6'h00
`define PTP_IDX_SHCTL  6'h01
`define PTP_IDX_WCTL   6'h02
`define PTP_IDX_RUN    6'h03
`define PTP_IDX_RELLO  6'h04
`define PTP_IDX_RELHI  6'h05
`define PTP_IDX_CAPLO  6'h06
`define PTP_IDX_CAPHI  6'h07
`define PTP_IDX_P3MODE 6'h08
`define PTP_IDX_PORT   6'h09
`define PTP_IDX_WREL   6'h0a
`define PTP_IDX_WCAP   6'h0b

// Field positions
`define PTP_B_EN      7
`define PTP_B_SINGLE  6
`define PTP_B_TO      5
`define PTP_B_CAPMSK  2
`define PTP_B_TOMSK   1
`define PTP_B_OUTSEL  0
`define PTP_B_MODE    7
`define PTP_B_ROUTE   6
`define PTP_B_RUNW    7
`define PTP_B_RUNB    6
`define PTP_B_SYNC    5
`define PTP_B_CMPEN   1
`define PTP_B_PIN1    4
`define PTP_B_PIN2    5
`define PTP_B_PIN3    6

// Constant values
`define PTP_RUN_RSVD  5'h1f
`define PTP_BYTE_FULL 8'hff
`define PTP_WORD_FULL 16'hffff
`define PTP_RST_BYTE  8'h00
`define PTP_RST_WORD  16'h0000

`endif

/* include/ptp_pkg.sv */
// Types of the pulse timer pair
package ptp_pkg;

    typedef enum logic [1:0] {
        PTP_LOG_AND  = 2'h0,
        PTP_LOG_OR   = 2'h1,
        PTP_LOG_NOR  = 2'h2,
        PTP_LOG_NAND = 2'h3
    } ptp_logic_t;

    typedef struct packed {
        logic        paddrOk;
        logic [5:0]  idx;
    } ptp_decode_t;

    typedef struct packed {
        logic        bEn, bSingle, bTo, bCapMask, bToMask, bOutSel;
        logic [1:0]  bPre;
        logic        mode, route;
        logic [1:0]  logicSel, glitch, status;
        logic        wEn, wSingle, wTo, wCapMask, wToMask, wOutSel;
        logic [1:0]  wPre;
        logic        sync;
        logic [7:0]  relLo, relHi, capLo, capHi, p3Mode, portOut;
        logic [15:0] wReload, wCap, wCnt;
        logic [7:0]  bCnt;
        logic        bRun, bOut, wRun, wOut;
        logic [2:0]  pre, fltCnt;
        logic        flt, fltPrev;
        logic        pready, pslverr;
        logic [31:0] prdata;
        logic        pin1, pin2, pin3, cmpEn, irqByte, irqWord;
    } ptp_state_t;

endpackage

/* verif/ptp_timer_props.sv */
// Port assertions of the pulse timer pair
`timescale 1ns/100ps
`default_nettype none

module ptp_timer_props (
    // Clock and reset
    input wire logic        clk,
    input wire logic        reset,
    // APB slave side
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pins and requests
    input wire logic        firstFixedOutputPin,
    input wire logic        secondFixedOutputPin,
    input wire logic        comparatorEnable,
    input wire logic        byteTimerIrq
);
    //--------------------------------------------------------------------
    // Shadow registers
    //--------------------------------------------------------------------
    logic [7:0] portSh_ff;
    logic [7:0] bctlSh_ff;
    logic       wOutSel_ff;
    logic [1:0] quiet_ff;
    logic       wrDone;
    logic       badAddr;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Accepted write and address decode
    assign wrDone  = pready && pwrite && !pslverr;
    assign badAddr = (paddr[1:0] != 2'h0) || (paddr > 8'h2c);

    // Pin and mask settings, and cycles since the last write (saturating)
    always_ff @(posedge clk) begin
        if (reset) begin
            portSh_ff  <= 8'h00;
            bctlSh_ff  <= 8'h00;
            wOutSel_ff <= 1'b0;
            quiet_ff   <= 2'h0;
        end else begin
            quiet_ff <= wrDone ? 2'h0 : ((quiet_ff == 2'h3) ? 2'h3 : quiet_ff + 2'h1);
            if (wrDone && paddr == 8'h24) portSh_ff <= pwdata[7:0];
            if (wrDone && paddr == 8'h00) bctlSh_ff <= pwdata[7:0];
            if (wrDone && paddr == 8'h08) wOutSel_ff <= pwdata[0];
        end
    end

    //--------------------------------------------------------------------
    // Properties
    //--------------------------------------------------------------------
    sequence s_access;
        psel && penable && !pready;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence

    a_apb_answer: assert property (s_access |=> s_answer)
        else $error("access not answered by a one-cycle ready");
    a_ready_cause: assert property ($rose(pready) |-> $past(psel && penable))
        else $error("ready without a request");
    a_err_unmapped: assert property (pready && badAddr |-> pslverr)
        else $error("bad address not refused");
    a_err_mapped: assert property (pready && !badAddr |-> !pslverr)
        else $error("good address refused");
    a_err_rdzero: assert property (pready && !pwrite && pslverr |-> prdata == 32'h0)
        else $error("refused read returns data");
    a_run_reserved: assert property (
        pready && !pwrite && paddr == 8'h0c |-> prdata[4:0] == 5'h1f)
        else $error("reserved run bits wrong");
    a_cmp_follow: assert property (
        wrDone && paddr == 8'h20 |=> ##1 comparatorEnable == $past(pwdata[1], 2))
        else $error("comparator enable not following mode bit");
    a_pin1_port: assert property (
        quiet_ff == 2'h3 && !bctlSh_ff[0] |-> firstFixedOutputPin == portSh_ff[4])
        else $error("first pin not port data");
    a_pin2_port: assert property (
        quiet_ff == 2'h3 && !wOutSel_ff |-> secondFixedOutputPin == portSh_ff[5])
        else $error("second pin not port data");
    a_irq_masked: assert property (
        quiet_ff == 2'h3 && bctlSh_ff[2:1] == 2'h0 |-> !byteTimerIrq)
        else $error("byte request with both masks off");
endmodule // ptp_timer_props

bind ptp_timer ptp_timer_props u_props (
    .clk                  (clk),
    .reset                (reset),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .paddr                (paddr),
    .pwdata               (pwdata),
    .prdata               (prdata),
    .pready               (pready),
    .pslverr              (pslverr),
    .firstFixedOutputPin  (firstFixedOutputPin),
    .secondFixedOutputPin (secondFixedOutputPin),
    .comparatorEnable     (comparatorEnable),
    .byteTimerIrq         (byteTimerIrq)
);

`default_nettype wire

/* verif/ptp_pin_model.sv */
// Far-side model: pulse train on the measured pins and comparator result
`timescale 1ns/100ps
`default_nettype none

module ptp_pin_model (
    // Clock
    input  wire logic       clk,
    // Pulse train settings
    input  wire logic       trainOn,
    input  wire logic [7:0] highLen,
    input  wire logic [7:0] lowLen,
    // Pin levels
    output var  logic       port3Bit1Input,
    output var  logic       port2Bit0Input,
    output var  logic       comparatorResult
);
    logic [7:0] cnt_ff;
    logic       lvl_ff;

    initial begin
        cnt_ff = 8'h00;
        lvl_ff = 1'b0;
    end

    // Low phase then high phase; the line rests low between trains
    always @(posedge clk) begin
        if (!trainOn) begin
            cnt_ff <= 8'h00;
            lvl_ff <= 1'b0;
        end else if (cnt_ff == (lvl_ff ? highLen : lowLen) - 8'h01) begin
            cnt_ff <= 8'h00;
            lvl_ff <= ~lvl_ff;
        end else begin
            cnt_ff <= cnt_ff + 8'h01;
        end
    end

    // Other pin carries the inverse, so a wrong pin choice shows up
    assign port3Bit1Input   = lvl_ff;
    assign port2Bit0Input   = ~lvl_ff;
    assign comparatorResult = lvl_ff;
endmodule // ptp_pin_model

`default_nettype wire

/* verif/ptp_timer_tb.sv */
// Self-checking bench of the pulse timer pair
`timescale 1ns/100ps
`default_nettype none
`include "ptp_defines.svh"
`define AD(i) {(i), 2'b00}
`define CHK(g, e, m) begin checks++; if ((g) !== (e)) begin errTotal++; \
    $display("BAD %0t %s", $time, m); end end

module ptp_timer_tb;
    logic        clk, reset, psel, penable, pwrite, trainOn, rerr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic        pready, pslverr, p31, p20, cmpRes, pin1, pin2, pin3, cmpEn, irqB, irqW;
    int          errTotal, checks, cyc;

    ptp_timer dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port3Bit1Input(p31),
        .port2Bit0Input(p20), .comparatorResult(cmpRes), .firstFixedOutputPin(pin1),
        .secondFixedOutputPin(pin2), .thirdFixedOutputPin(pin3),
        .comparatorEnable(cmpEn), .byteTimerIrq(irqB), .wordTimerIrq(irqW));
    ptp_pin_model pm (.clk(clk), .trainOn(trainOn), .highLen(8'h14), .lowLen(8'h28),
        .port3Bit1Input(p31), .port2Bit0Input(p20), .comparatorResult(cmpRes));

    // Clock and hang guard
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errTotal++;
            conclude();
        end
    end

    task automatic conclude();
        if (errTotal == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // One APB transfer; waits for ready, then idles one cycle
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                         input string s);
        apb(1'b0, a, 32'h0);
        `CHK(rdat & m, e, s)
    endtask

    // Reset values, refused accesses, reserved bits, comparator enable
    task automatic tRegs();
        for (int i = 0; i < 12; i++) begin
            rdChk(`AD(i[5:0]), 32'hffffffff, (i == 3) ? 32'h1f : 32'h0, "reset value");
        end
        apb(1'b0, 8'h30, 32'h0);
        `CHK({rerr, rdat}, 33'h100000000, "unmapped read")
        apb(1'b1, 8'h05, 32'hff);
        `CHK(rerr, 1'b1, "misaligned write")
        wr(`AD(`PTP_IDX_RUN), 32'h20);
        rdChk(`AD(`PTP_IDX_RUN), 32'hff, 32'h3f, "run control read");
        for (int v = 0; v < 2; v++) begin
            wr(`AD(`PTP_IDX_P3MODE), {30'h0, v[0], 1'b0});
            tick(3);
            `CHK(cmpEn, v[0], "comparator enable")
        end
    endtask

    // Port data, idle byte output and output combiner on the pins
    task automatic tPins();
        logic b, w, ex;
        wr(`AD(`PTP_IDX_PORT), 32'h70);
        tick(3);
        `CHK({pin3, pin2, pin1}, 3'b111, "port data on pins")
        wr(`AD(`PTP_IDX_PORT), 32'h20);
        wr(`AD(`PTP_IDX_BCTL), 32'h01);
        wr(`AD(`PTP_IDX_WCTL), 32'h01);
        tick(3);
        `CHK(pin2, 1'b0, "word output on second pin")
        w = 1'b0;
        for (int v = 0; v < 8; v++) begin
            wr(`AD(`PTP_IDX_SHCTL), {24'h0, 2'b01, v[1:0], 2'b00, v[2], 1'b0});
            tick(3);
            b = ~v[2];
            ex = v[1] ^ ((v[1] ^ v[0]) ? (b | w) : (b & w));
            `CHK(pin1, b, "idle byte output")
            `CHK(pin3, ex, "combined output")
        end
        wr(`AD(`PTP_IDX_SHCTL), 32'h0);
        wr(`AD(`PTP_IDX_WCTL), 32'h5e);
        rdChk(`AD(`PTP_IDX_WCTL), 32'hff, 32'h5e, "word control fields");
        wr(`AD(`PTP_IDX_WCTL), 32'h80);
        rdChk(`AD(`PTP_IDX_WCTL), 32'h80, 32'h80, "word run read");
        wr(`AD(`PTP_IDX_WCTL), 32'h00);
        rdChk(`AD(`PTP_IDX_WCTL), 32'h80, 32'h00, "word stop read");
        wr(`AD(`PTP_IDX_WCTL), 32'he0);
        rdChk(`AD(`PTP_IDX_WCTL), 32'ha0, 32'h20, "single pass stop");
        wr(`AD(`PTP_IDX_WCTL), 32'h02);
        tick(2);
        `CHK(irqW, 1'b1, "word timeout request")
        wr(`AD(`PTP_IDX_WCTL), 32'h22);
        tick(2);
        `CHK(irqW, 1'b0, "word timeout cleared")
    endtask

    // Demodulation: start edge, captures, status, timeout
    task automatic tDemod();
        wr(`AD(`PTP_IDX_RELLO), 32'hff);
        wr(`AD(`PTP_IDX_RELHI), 32'hff);
        wr(`AD(`PTP_IDX_SHCTL), 32'ha0);
        wr(`AD(`PTP_IDX_BCTL), 32'h86);
        tick(300);
        rdChk(`AD(`PTP_IDX_BCTL), 32'h20, 32'h0, "no count before edge");
        trainOn <= 1'b1;
        tick(150);
        while (p31 !== 1'b0) tick(1);
        trainOn <= 1'b0;
        apb(1'b0, `AD(`PTP_IDX_CAPLO), 32'h0);
        `CHK(rdat >= 32'h27 && rdat <= 32'h29, 1'b1, "low capture")
        apb(1'b0, `AD(`PTP_IDX_CAPHI), 32'h0);
        `CHK(rdat >= 32'h13 && rdat <= 32'h15, 1'b1, "high capture")
        rdChk(`AD(`PTP_IDX_SHCTL), 32'h03, 32'h03, "capture status");
        `CHK(irqB, 1'b1, "capture request")
        wr(`AD(`PTP_IDX_SHCTL), 32'ha3);
        tick(2);
        `CHK(irqB, 1'b0, "capture request cleared")
        tick(300);
        rdChk(`AD(`PTP_IDX_BCTL), 32'h20, 32'h20, "timeout flag");
        `CHK(irqB, 1'b1, "timeout request")
        wr(`AD(`PTP_IDX_BCTL), 32'h06);
        rdChk(`AD(`PTP_IDX_BCTL), 32'ha0, 32'h20, "stopped, flag kept");
        wr(`AD(`PTP_IDX_BCTL), 32'h26);
        rdChk(`AD(`PTP_IDX_BCTL), 32'h20, 32'h00, "flag cleared");
        tick(2);
        `CHK(irqB, 1'b0, "timeout request cleared")
    endtask

    // Main sequence
    initial begin
        clk = 1'b0;
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        trainOn = 1'b0;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        tRegs();
        tPins();
        tDemod();
        conclude();
    end
endmodule // ptp_timer_tb

`default_nettype wire
